// ==== verilog/asq_pkg.sv ====
// Constants, register map and state types of the converter sequencer.
// Assumes an APB master on pclk and an external SAR analog core.
// Functional notes
// - Convert one of 16+8 multiplexed channels at a time into 10 bits.
// - Software programs sample duration and per-bit conversion duration.
// - One control bit selects which port supplies the extra input group.
// - Self-calibration up to 40630 cycles after reset, busy flag set throughout.
// - Starts are refused during calibration; software polls busy first.
// - Calibration runs only after reset, never again in normal operation.
// - Single channel single mode converts once and stores the result.
// - Single channel continuous mode repeats conversions, storing each result.
// - Scan single mode converts each channel of the set once, then stops.
// - Scan continuous mode cycles the channel set without stopping.
// - In scan modes each result is stored as soon as it ends, except when wait-for-read holds it in scan continuous mode.
// - Result finished while previous unread and hold off raises overrun.
// - Wait-for-read in continuous mode buffers result and pauses until read.
// - Injection converts a chosen channel into the injection result register.
// - After injection the continuous mode resumes unchanged.
// - Unused analog inputs can be read as digital inputs.
package asq_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int unsigned NUM_CH  = 24;
   localparam int unsigned CH_W    = 5;
   localparam int unsigned RES_W   = 10;
   localparam int unsigned ADDR_W  = 12;
   localparam logic [4:0]  CH_LIMIT = 5'h18;

   // ------------------------------------------------------------
   // Cycle counts
   // ------------------------------------------------------------
   localparam int unsigned CAL_CYCLES_DFLT = 40630;
   localparam logic [7:0]  RST_SAMP_CYC    = 8'h08;
   localparam logic [7:0]  RST_BIT_CYC     = 8'h08;
   localparam logic [7:0]  MIN_BIT_CYC     = 8'h06;

   // ------------------------------------------------------------
   // Register byte addresses
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_TIME = 12'h004;
   localparam logic [11:0] ADDR_RES  = 12'h008;
   localparam logic [11:0] ADDR_INJ  = 12'h00C;
   localparam logic [11:0] ADDR_STAT = 12'h010;
   localparam logic [11:0] ADDR_DIG  = 12'h014;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int unsigned CTL_CH_LSB   = 0;
   localparam int unsigned CTL_MODE_LSB = 5;
   localparam int unsigned CTL_RUN_BIT  = 7;
   localparam int unsigned CTL_WFR_BIT  = 8;
   localparam int unsigned CTL_GRP_BIT  = 9;
   localparam int unsigned TIM_SAMP_LSB = 0;
   localparam int unsigned TIM_BIT_LSB  = 8;
   localparam int unsigned RES_VAL_LSB  = 0;
   localparam int unsigned RES_CH_LSB   = 10;
   localparam int unsigned INJ_REQ_BIT  = 15;
   localparam int unsigned INJ_SEL_LSB  = 16;
   localparam int unsigned STA_BUSY_BIT = 0;
   localparam int unsigned STA_CAL_BIT  = 1;
   localparam int unsigned STA_UNRD_BIT = 2;
   localparam int unsigned STA_OVR_BIT  = 3;
   localparam int unsigned STA_HOLD_BIT = 4;

   // Mode field: bit 0 continuous, bit 1 scan
   localparam logic [1:0] MODE_SINGLE    = 2'b00;
   localparam logic [1:0] MODE_CONT      = 2'b01;
   localparam logic [1:0] MODE_SCAN      = 2'b10;
   localparam logic [1:0] MODE_SCAN_CONT = 2'b11;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [4:0]
   {
      S_CAL    = 5'h01,
      S_IDLE   = 5'h02,
      S_SAMPLE = 5'h04,
      S_CONV   = 5'h08,
      S_HOLD   = 5'h10
   } asq_state_e;

   // Signals toward the analog core
   typedef struct packed {
      logic [4:0] mux_ch;
      logic       ext_port_sel;
      logic       sample;
      logic [9:0] dac_code;
      logic       cal_active;
   } asq_ana_s;

   typedef struct packed {
      asq_state_e  st;
      logic [15:0] cnt;
      logic [3:0]  bit_i;
      logic [9:0]  code;
      logic [4:0]  cur_ch;
      logic [4:0]  conv_ch;
      logic        conv_inj;
      logic [4:0]  ctl_ch;
      logic [1:0]  mode;
      logic        run;
      logic        wfr;
      logic        grp;
      logic [7:0]  samp_cyc;
      logic [7:0]  bit_cyc;
      logic [9:0]  res_val;
      logic [4:0]  res_ch;
      logic        unread;
      logic [9:0]  tmp_val;
      logic [4:0]  tmp_ch;
      logic [9:0]  inj_val;
      logic [4:0]  inj_rch;
      logic [4:0]  inj_ch;
      logic        inj_pend;
      logic        ovr;
      logic        eoc;
      logic        ovr_irq;
      logic        inj_done;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } asq_regs_s;

   localparam asq_regs_s REGS_RST = '{st: S_CAL, samp_cyc: RST_SAMP_CYC,
                                      bit_cyc: RST_BIT_CYC, default: '0};

endpackage

// ==== verilog/asq_sync.sv ====
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output moves once stages two and three agree.
`timescale 1ns/1ps
module asq_sync
#(
   parameter int unsigned W = 1
)
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } asq_sync_s;

   asq_sync_s st_r;
   asq_sync_s st_nxt;

   // Stage one feeds only stage two, keeping metastability out of the filter
   always_comb
   begin
      st_nxt    = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int i = 0; i < W; i++)
      begin
         if (st_r.s2[i] == st_r.s3[i])
         begin
            st_nxt.q[i] = st_r.s3[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.q;

endmodule

// ==== verilog/asq_top.sv ====
// Converter sequencer: calibration, modes, scan, injection, overrun, APB slave.
// Assumes an external SAR core taking mux, sample and trial code outputs,
// returning a comparator level (high when input is at or above the code).
`timescale 1ns/1ps
module asq_top
   import asq_pkg::*;
#(
   parameter int unsigned CAL_CYCLES = CAL_CYCLES_DFLT
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        cmp_in,
   input  wire logic [23:0] dig_pins,
   output asq_ana_s         ana,
   output logic             eoc_req,
   output logic             ovr_req,
   output logic             inj_req
);

   localparam logic [15:0] CAL_LAST = 16'(CAL_CYCLES - 1);

   asq_regs_s   st_r;
   asq_regs_s   st_nxt;
   logic        cmp_s;
   logic [23:0] dig_s;
   logic        acc;
   logic        done;
   logic        wr;
   logic        rd;
   logic        rd_res;
   logic        hit;
   logic [15:0] samp_last;
   logic [15:0] bit_last;

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   asq_sync #(.W(1)) u_cmp_sync
   (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (cmp_in),
      .q       (cmp_s)
   );

   // Analog pins read as digital inputs
   asq_sync #(.W(24)) u_dig_sync
   (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (dig_pins),
      .q       (dig_s)
   );

   // ------------------------------------------------------------
   // Bus decode and phase lengths
   // ------------------------------------------------------------
   // One wait state so read data can come from a flip-flop
   assign acc    = psel & penable;
   assign done   = acc & st_r.pready;
   assign hit    = (paddr == ADDR_CTRL) || (paddr == ADDR_TIME) || (paddr == ADDR_RES) ||
                   (paddr == ADDR_INJ) || (paddr == ADDR_STAT) || (paddr == ADDR_DIG);
   assign wr     = done & pwrite & hit;
   assign rd     = done & ~pwrite & hit;
   assign rd_res = rd & (paddr == ADDR_RES);
   assign samp_last = (st_r.samp_cyc == 8'h00) ? 16'h0000 : {8'h00, st_r.samp_cyc - 8'h01};
   // Bit time floor covers the comparator synchroniser latency
   assign bit_last  = (st_r.bit_cyc < MIN_BIT_CYC) ? {8'h00, MIN_BIT_CYC - 8'h01}
                                                   : {8'h00, st_r.bit_cyc - 8'h01};

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb
   begin
      logic [9:0]  new_code;
      logic [31:0] rdv;
      logic        go;
      st_nxt   = st_r;
      new_code = st_r.code;
      rdv      = 32'h0000_0000;
      go       = 1'b0;
      st_nxt.eoc      = 1'b0;
      st_nxt.ovr_irq  = 1'b0;
      st_nxt.inj_done = 1'b0;

      // Read data mux
      if (paddr == ADDR_CTRL)
      begin
         rdv[CTL_CH_LSB +: 5]   = st_r.ctl_ch;
         rdv[CTL_MODE_LSB +: 2] = st_r.mode;
         rdv[CTL_RUN_BIT]       = st_r.run;
         rdv[CTL_WFR_BIT]       = st_r.wfr;
         rdv[CTL_GRP_BIT]       = st_r.grp;
      end
      else if (paddr == ADDR_TIME)
      begin
         rdv[TIM_SAMP_LSB +: 8] = st_r.samp_cyc;
         rdv[TIM_BIT_LSB +: 8]  = st_r.bit_cyc;
      end
      else if (paddr == ADDR_RES)
      begin
         rdv[RES_VAL_LSB +: 10] = st_r.res_val;
         rdv[RES_CH_LSB +: 5]   = st_r.res_ch;
      end
      else if (paddr == ADDR_INJ)
      begin
         rdv[RES_VAL_LSB +: 10] = st_r.inj_val;
         rdv[RES_CH_LSB +: 5]   = st_r.inj_rch;
         rdv[INJ_REQ_BIT]       = st_r.inj_pend;
         rdv[INJ_SEL_LSB +: 5]  = st_r.inj_ch;
      end
      else if (paddr == ADDR_STAT)
      begin
         rdv[STA_BUSY_BIT] = (st_r.st != S_IDLE);
         rdv[STA_CAL_BIT]  = (st_r.st == S_CAL);
         rdv[STA_UNRD_BIT] = st_r.unread;
         rdv[STA_OVR_BIT]  = st_r.ovr;
         rdv[STA_HOLD_BIT] = (st_r.st == S_HOLD);
      end
      else if (paddr == ADDR_DIG)
      begin
         rdv[23:0] = dig_s;
      end

      // APB handshake: answer one cycle into the access phase
      if (acc && !st_r.pready)
      begin
         st_nxt.pready  = 1'b1;
         st_nxt.prdata  = rdv;
         st_nxt.pslverr = ~hit;
      end
      else
      begin
         st_nxt.pready  = 1'b0;
         st_nxt.pslverr = 1'b0;
      end

      // Register writes
      if (wr && (paddr == ADDR_CTRL))
      begin
         if (pwdata[CTL_CH_LSB +: 5] < CH_LIMIT)
         begin
            st_nxt.ctl_ch = pwdata[CTL_CH_LSB +: 5];
         end
         st_nxt.mode = pwdata[CTL_MODE_LSB +: 2];
         st_nxt.wfr  = pwdata[CTL_WFR_BIT];
         st_nxt.grp  = pwdata[CTL_GRP_BIT];
         // A start written during calibration is dropped
         if (st_r.st != S_CAL)
         begin
            st_nxt.run = pwdata[CTL_RUN_BIT];
            if (pwdata[CTL_RUN_BIT] && !st_r.run)
            begin
               st_nxt.cur_ch = st_nxt.ctl_ch;
            end
         end
      end
      if (wr && (paddr == ADDR_TIME))
      begin
         st_nxt.samp_cyc = pwdata[TIM_SAMP_LSB +: 8];
         st_nxt.bit_cyc  = pwdata[TIM_BIT_LSB +: 8];
      end
      if (wr && (paddr == ADDR_INJ))
      begin
         if (pwdata[INJ_SEL_LSB +: 5] < CH_LIMIT)
         begin
            st_nxt.inj_ch = pwdata[INJ_SEL_LSB +: 5];
         end
         // Injection only accepted while a continuous mode runs
         if (pwdata[INJ_REQ_BIT] && st_r.run && st_r.mode[0])
         begin
            st_nxt.inj_pend = 1'b1;
         end
      end
      if (wr && (paddr == ADDR_STAT) && pwdata[STA_OVR_BIT])
      begin
         st_nxt.ovr = 1'b0;
      end
      // Reading the result clears unread; a new result later this cycle wins
      if (rd_res)
      begin
         st_nxt.unread = 1'b0;
      end

      // Sequencer
      case (st_r.st)
         S_CAL:
         begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
            if (st_r.cnt == CAL_LAST)
            begin
               st_nxt.st  = S_IDLE;
               st_nxt.cnt = 16'h0000;
            end
         end
         S_IDLE:
         begin
            go = st_nxt.run;
         end
         S_SAMPLE:
         begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
            if (st_r.cnt >= samp_last)
            begin
               st_nxt.st    = S_CONV;
               st_nxt.cnt   = 16'h0000;
               st_nxt.bit_i = 4'h9;
               st_nxt.code  = 10'h200;
            end
         end
         S_CONV:
         begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
            if (st_r.cnt >= bit_last)
            begin
               st_nxt.cnt = 16'h0000;
               // Trial bit kept only if the input is at or above the code
               if (!cmp_s)
               begin
                  new_code[st_r.bit_i] = 1'b0;
               end
               st_nxt.code = new_code;
               if (st_r.bit_i != 4'h0)
               begin
                  st_nxt.bit_i = st_r.bit_i - 4'h1;
                  st_nxt.code[st_r.bit_i - 4'h1] = 1'b1;
               end
               else if (st_r.conv_inj)
               begin
                  st_nxt.inj_val  = new_code;
                  st_nxt.inj_rch  = st_r.conv_ch;
                  st_nxt.inj_done = 1'b1;
                  go = 1'b1;
               end
               else
               begin
                  if (st_nxt.unread && st_r.wfr && st_r.mode[0])
                  begin
                     st_nxt.tmp_val = new_code;
                     st_nxt.tmp_ch  = st_r.conv_ch;
                     st_nxt.st      = S_HOLD;
                  end
                  else
                  begin
                     if (st_nxt.unread)
                     begin
                        st_nxt.ovr     = 1'b1;
                        st_nxt.ovr_irq = 1'b1;
                     end
                     st_nxt.res_val = new_code;
                     st_nxt.res_ch  = st_r.conv_ch;
                     st_nxt.unread  = 1'b1;
                     st_nxt.eoc     = 1'b1;
                     go = 1'b1;
                  end
                  // Channel advance for the next normal conversion
                  if (st_r.mode[1])
                  begin
                     if (st_r.cur_ch == 5'h00)
                     begin
                        if (st_r.mode[0])
                        begin
                           st_nxt.cur_ch = st_r.ctl_ch;
                        end
                        else
                        begin
                           st_nxt.run = 1'b0;
                        end
                     end
                     else
                     begin
                        st_nxt.cur_ch = st_r.cur_ch - 5'h01;
                     end
                  end
                  else if (!st_r.mode[0])
                  begin
                     st_nxt.run = 1'b0;
                  end
               end
            end
         end
         S_HOLD:
         begin
            if (rd_res)
            begin
               st_nxt.res_val = st_r.tmp_val;
               st_nxt.res_ch  = st_r.tmp_ch;
               st_nxt.unread  = 1'b1;
               st_nxt.eoc     = 1'b1;
               go = 1'b1;
            end
         end
         default:
         begin
            st_nxt.st = S_IDLE;
         end
      endcase

      // Launch the next conversion; a pending injection goes first
      if (go)
      begin
         st_nxt.cnt = 16'h0000;
         if (st_nxt.run)
         begin
            st_nxt.st = S_SAMPLE;
            if (st_nxt.inj_pend && st_nxt.mode[0])
            begin
               st_nxt.conv_inj = 1'b1;
               st_nxt.conv_ch  = st_nxt.inj_ch;
               st_nxt.inj_pend = 1'b0;
            end
            else
            begin
               st_nxt.conv_inj = 1'b0;
               st_nxt.conv_ch  = st_nxt.cur_ch;
            end
         end
         else
         begin
            st_nxt.st       = S_IDLE;
            st_nxt.inj_pend = 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= REGS_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign prdata  = st_r.prdata;
   assign pready  = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign eoc_req = st_r.eoc;
   assign ovr_req = st_r.ovr_irq;
   assign inj_req = st_r.inj_done;
   assign ana     = '{mux_ch: st_r.conv_ch, ext_port_sel: st_r.grp, sample: st_r.st[2],
                      dac_code: st_r.code, cal_active: st_r.st[0]};

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_CAL_HOLDS: assert property ((st_r.st == S_CAL && st_r.cnt < CAL_LAST) |=>
      st_r.st == S_CAL) else $error("calibration ended early");
   AST_CAL_NO_RUN: assert property (st_r.st == S_CAL |-> !st_r.run)
      else $error("start accepted during calibration");
   AST_NO_RECAL: assert property (st_r.st != S_CAL |=> st_r.st != S_CAL)
      else $error("calibration re-entered");
   AST_SAMPLE_LEN: assert property (st_r.st == S_SAMPLE |-> st_r.cnt <= samp_last)
      else $error("sample phase overran");
   AST_BIT_STEP: assert property ((st_r.st == S_CONV && st_r.cnt >= bit_last &&
      st_r.bit_i != 4'h0) |=> st_r.bit_i == $past(st_r.bit_i) - 4'h1 && st_r.st == S_CONV)
      else $error("SAR bit step wrong");
   AST_EOC_UNREAD: assert property (st_r.eoc |-> st_r.unread && st_r.st != S_HOLD)
      else $error("end of conversion without unread result");
   AST_OVR_EOC: assert property (st_r.ovr_irq |-> st_r.eoc && st_r.ovr)
      else $error("overrun without result write");
   AST_HOLD_WAIT: assert property ((st_r.st == S_HOLD && !rd_res) |=>
      st_r.st == S_HOLD && !st_r.eoc) else $error("hold left without read");
   AST_SINGLE_STOP: assert property ((st_r.eoc && $past(st_r.mode) == MODE_SINGLE &&
      st_r.mode == MODE_SINGLE) |-> !st_r.run) else $error("single mode kept running");
   AST_INJ_RESUME: assert property (st_r.inj_done |-> st_r.cur_ch == $past(st_r.cur_ch) &&
      st_r.run == $past(st_r.run)) else $error("injection disturbed sequence");
   AST_APB_WAIT: assert property ((acc && !st_r.pready) |=> st_r.pready)
      else $error("bus answer late");

   COV_SCAN_EOC: cover property (st_r.eoc && st_r.mode == MODE_SCAN_CONT);
   COV_INJ: cover property (st_r.inj_done);
   COV_OVR: cover property (st_r.ovr_irq);
   COV_HOLD: cover property (st_r.st == S_CONV ##1 st_r.st == S_HOLD);

endmodule

// ==== test/asq_ana_model.sv ====
// Behavioural analog core: channel mux and comparator, with no sample-and-hold.
// Assumes the sequencer drives mux channel and SAR trial code as registers.
`timescale 1ns/1ps
module asq_ana_model
   import asq_pkg::*;
(
   input  asq_ana_s   ana,
   output logic       cmp_in
);
   logic [9:0] level;

   // ------------------------------------------------------------
   // Input levels
   // ------------------------------------------------------------
   // Each channel carries a distinct level, so a wrong mux shows in the code
   assign level  = {ana.mux_ch, 5'h15};
   // High when the input is at or above the trial code
   assign cmp_in = (level >= ana.dac_code);
endmodule

// ==== test/test_adc_sequencer_control.sv ====
// Bench for the converter sequencer: APB tasks and mode scenarios.
// Assumes asq_top and the behavioural analog model in this folder.
`timescale 1ns/1ps
module test_adc_sequencer_control;
   import asq_pkg::*;
   localparam int unsigned CAL = 16;
   logic        pclk     = 1'b0;
   logic        presetn  = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [11:0] paddr    = 12'h000;
   logic [31:0] pwdata   = 32'h0;
   logic [23:0] dig_pins = 24'hA5C3F0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready;
   logic        pslverr;
   logic        er;
   logic        cmp_in;
   logic        eoc_req;
   logic        ovr_req;
   logic        inj_req;
   asq_ana_s    ana;
   int          errors, tests_run, n_eoc, n_ovr, n_inj, b, ov;

   asq_top #(.CAL_CYCLES(CAL)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_in(cmp_in),
      .dig_pins(dig_pins), .ana(ana), .eoc_req(eoc_req), .ovr_req(ovr_req),
      .inj_req(inj_req));
   asq_ana_model model (.ana(ana), .cmp_in(cmp_in));

   // ------------------------------------------------------------
   // Clock, event counters, helpers
   // ------------------------------------------------------------
   initial forever #25 pclk = ~pclk;

   // Pulses last one cycle, so they are counted rather than waited for
   always @(posedge pclk)
   begin
      n_eoc += (eoc_req === 1'b1);
      n_ovr += (ovr_req === 1'b1);
      n_inj += (inj_req === 1'b1);
   end

   function automatic logic [31:0] res(input int ch);
      return (32'(ch) << RES_CH_LSB) | 32'((ch * 32 + 21) % 1024);
   endfunction

   function automatic logic [31:0] ctl(input int ch, input logic [1:0] m, input logic w, g);
      return 32'(ch) | (32'(m) << CTL_MODE_LSB) | 32'h80 | (32'(w) << 8) | (32'(g) << 9);
   endfunction

   task end_sim;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Holds the request until pready is sampled high, then idles one cycle
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      // Read data and error are taken at the edge where pready is sampled high
      do
      begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1)
      begin
         chk("bus answer", 32'h0, 32'h1);
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // A wait that runs out counts as a mismatch
   task automatic wait_cnt(ref int n, input int tgt);
      for (int i = 0; i < 2000 && n < tgt; i++)
      begin
         @(posedge pclk);
      end
      if (n < tgt)
      begin
         chk("event wait", 32'h0, 32'h1);
      end
   endtask

   // Software polls busy before it asks for a conversion
   task idle;
      for (int i = 0; i < 400; i++)
      begin
         apb(1'b0, ADDR_STAT, 32'h0);
         if (rd[STA_BUSY_BIT] === 1'b0) break;
      end
      if (rd[STA_BUSY_BIT] !== 1'b0)
      begin
         chk("busy poll", 32'h1, 32'h0);
      end
   endtask

   task stop;
      apb(1'b1, ADDR_CTRL, 32'h0);
      idle();
      apb(1'b0, ADDR_RES, 32'h0);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b1, ADDR_CTRL, ctl(5, MODE_SINGLE, 1'b0, 1'b0));
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("stat calibrating", rd, 32'h3);
      idle();
      chk("busy after cal", 32'(rd[0]), 32'h0);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("start refused", rd, 32'h5);
      apb(1'b0, ADDR_TIME, 32'h0);
      chk("time reset", rd, 32'h808);
      apb(1'b1, ADDR_TIME, 32'h601);
      apb(1'b0, 12'h018, 32'h0);
      chk("unmapped err", 32'(er), 32'h1);
      apb(1'b0, ADDR_DIG, 32'h0);
      chk("digital pins", rd, 32'hA5C3F0);
      b = n_eoc;
      apb(1'b1, ADDR_CTRL, ctl(5, MODE_SINGLE, 1'b0, 1'b0));
      wait_cnt(n_eoc, b + 1);
      apb(1'b0, ADDR_RES, 32'h0);
      chk("single result", rd, res(5));
      idle();
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("run cleared", rd, 32'h5);
      chk("single eoc count", 32'(n_eoc), 32'(b + 1));
      b = n_eoc;
      apb(1'b1, ADDR_CTRL, ctl(2, MODE_SCAN, 1'b0, 1'b1));
      chk("port select", 32'(ana.ext_port_sel), 32'h1);
      for (int i = 0; i < 3; i++)
      begin
         wait_cnt(n_eoc, b + i + 1);
         apb(1'b0, ADDR_RES, 32'h0);
         chk("scan result", rd, res(2 - i));
      end
      idle();
      chk("scan stops", 32'(n_eoc), 32'(b + 3));
      b = n_eoc;
      apb(1'b1, ADDR_CTRL, ctl(1, MODE_SCAN_CONT, 1'b0, 1'b0));
      for (int i = 0; i < 4; i++)
      begin
         wait_cnt(n_eoc, b + i + 1);
         apb(1'b0, ADDR_RES, 32'h0);
         chk("scan wrap", rd, res(1 - i % 2));
      end
      stop();
      b = n_eoc;
      ov = n_ovr;
      apb(1'b1, ADDR_CTRL, ctl(3, MODE_CONT, 1'b0, 1'b0));
      wait_cnt(n_eoc, b + 2);
      chk("overrun pulse", 32'(n_ovr), 32'(ov + 1));
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("overrun flag", 32'(rd[STA_OVR_BIT]), 32'h1);
      // Sticky flag clears by writing one, long before the next result lands
      apb(1'b1, ADDR_STAT, 32'h8);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("overrun cleared", 32'(rd[STA_OVR_BIT]), 32'h0);
      apb(1'b0, ADDR_RES, 32'h0);
      chk("cont result", rd, res(3));
      stop();
      b = n_eoc;
      ov = n_ovr;
      apb(1'b1, ADDR_CTRL, ctl(4, MODE_CONT, 1'b1, 1'b0));
      wait_cnt(n_eoc, b + 1);
      repeat (200) @(posedge pclk);
      chk("held no overrun", 32'(n_ovr), 32'(ov));
      chk("held no eoc", 32'(n_eoc), 32'(b + 1));
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("hold flag", 32'(rd[STA_HOLD_BIT]), 32'h1);
      apb(1'b0, ADDR_RES, 32'h0);
      wait_cnt(n_eoc, b + 2);
      apb(1'b0, ADDR_RES, 32'h0);
      chk("buffered result", rd, res(4));
      stop();
      b = n_inj;
      apb(1'b1, ADDR_CTRL, ctl(6, MODE_CONT, 1'b0, 1'b0));
      apb(1'b1, ADDR_INJ, 32'h78000);
      wait_cnt(n_inj, b + 1);
      apb(1'b0, ADDR_INJ, 32'h0);
      chk("inject result", rd, 32'h70000 | res(7));
      b = n_eoc;
      wait_cnt(n_eoc, b + 1);
      apb(1'b0, ADDR_RES, 32'h0);
      chk("resumed", rd, res(6));
      stop();
      chk("no recalibration", 32'(ana.cal_active), 32'h0);
      end_sim();
   end

   // Whole run needs under two thousand cycles; this allows twenty thousand
   initial
   begin
      #1000000;
      errors++;
      end_sim();
   end
endmodule
